// ==== hdl/bkp_slave.sv ====
// File: backplane slave for block writes and four-level interrupts
// Function
// - Slave replies to strobe; continue with reply if room remains.
// - Continue stable within 75 ns of reply, held 20 ns past strobe.
// - Slave drops reply only after the strobe drops.
// - Request only when enabled and pending, with level's lines.
// - Request lines stay until acknowledged.
// - Non-requesting device passes acknowledge down the chain.
// - Requesting device below level 6 yields to active higher request lines.
// - Equal priority goes to device nearest the processor.
// - Fixed vector below octal 001000 pointing to handler pair.
// - Winner blocks acknowledge, latched at in strobe leading edge.
// - Winner replies with vector on low 16 lines, removed after.
`timescale 1ns/1ps
module bkp_slave
  import bkp_pkg::*;
#(
  parameter logic [1:0] IRQ_LEVEL = LVL_4,
  parameter logic [VEC_W-1:0] VECTOR = VEC_DEFAULT,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire bus_in_s i_bus,
  input wire logic [DATA_W-1:0] i_muxed_addr_data,
  input wire irq_s i_irq_lines,
  output logic o_slave_reply,
  output logic o_refresh_block_continue,
  output logic [DATA_W-1:0] o_muxed_addr_data,
  output logic o_muxed_addr_data_oe,
  output logic o_ack_chain_out,
  output irq_s o_irq,
  input wire logic i_irq_enable,
  input wire logic i_irq_condition,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [DATA_W-1:0] o_wr_data
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int unsigned SW = $bits(bus_in_s) + DATA_W + $bits(irq_s);
  logic [SW-1:0] s1_q, s2_q;
  bus_in_s bus;
  logic [DATA_W-1:0] dat;
  irq_s lines;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {i_bus, i_muxed_addr_data, i_irq_lines};
      s2_q <= s1_q;
    end
  end

  always_comb begin
    {bus, dat, lines} = s2_q;
  end

  // ****************************************************************
  // Write FIFO
  // ****************************************************************
  logic push;
  logic fifo_ready;

  bkp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data(dat),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(o_wr_data)
  );

  // ****************************************************************
  // Slave state machine
  // ****************************************************************
  function automatic logic higher_active(input irq_s l, input logic [1:0] v);
    case (v)
      LVL_4: higher_active = l.irq_level_five || l.irq_level_six;
      LVL_5: higher_active = l.irq_level_six;
      default: higher_active = 1'b0;
    endcase
  endfunction

  slv_state_e st_q, st_d;
  logic reply_q, reply_d;
  logic cont_q, cont_d;
  logic oe_q, oe_d;
  logic [DATA_W-1:0] drv_q, drv_d;
  logic ack_out_q, ack_out_d;
  logic block_q, block_d;
  logic pend_q, pend_d;
  logic din_q, din_d;
  logic [7:0] hold_q, hold_d;
  irq_s irq_q, irq_d;
  localparam int unsigned OW = $clog2(DEPTH) + 1;
  logic [OW-1:0] occ_q, occ_d;

  always_comb begin
    st_d = st_q;
    reply_d = reply_q;
    cont_d = cont_q;
    oe_d = oe_q;
    drv_d = drv_q;
    ack_out_d = 1'b0;
    block_d = block_q;
    pend_d = pend_q;
    hold_d = (hold_q != '0) ? hold_q - 8'h01 : hold_q;
    push = 1'b0;
    din_d = bus.in_strobe;
    if (i_irq_enable && i_irq_condition) begin
      pend_d = 1'b1;
    end
    // Winner decision latched on in strobe leading edge
    if (bus.in_strobe && !din_q) begin
      block_d = pend_q && !higher_active(lines, IRQ_LEVEL);
    end
    if (!bus.in_strobe) begin
      block_d = 1'b0;
    end
    case (st_q)
      ST_IDLE: begin
        if (bus.cycle_sync && bus.out_strobe && bus.write_byte_ctl) begin
          if (fifo_ready) begin
            push = 1'b1;
            reply_d = 1'b1;
            // Room for two more beyond this word
            cont_d = bus.block_request_line &&
              (occ_q < OW'(DEPTH - 2));
            st_d = ST_WAIT_NEG;
          end
        end else if (bus.in_strobe && bus.ack_chain_in) begin
          if (block_q) begin
            st_d = ST_VEC;
          end else if (din_q) begin
            st_d = ST_PASS;
          end
        end
      end
      ST_WAIT_NEG: begin
        if (!bus.out_strobe) begin
          reply_d = 1'b0;
          hold_d = 8'(CONT_HOLD_CYC);
          st_d = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (hold_q == '0) begin
          cont_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      ST_VEC: begin
        drv_d = VECTOR;
        oe_d = 1'b1;
        reply_d = 1'b1;
        if (!bus.in_strobe) begin
          reply_d = 1'b0;
          oe_d = 1'b0;
          pend_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      ST_PASS: begin
        ack_out_d = bus.ack_chain_in;
        if (!bus.in_strobe || !bus.ack_chain_in) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Own count of queued words
    occ_d = occ_q + OW'(push) - OW'(o_wr_valid && i_wr_ready);
    if (i_irq_enable && i_irq_condition && st_q != ST_VEC) begin
      pend_d = 1'b1;
    end
    irq_d.irq_level_four = pend_d;
    irq_d.irq_level_five = pend_d && IRQ_LEVEL == LVL_5;
    irq_d.irq_level_six = pend_d && (IRQ_LEVEL == LVL_6 || IRQ_LEVEL == LVL_7);
    irq_d.irq_level_seven = pend_d && IRQ_LEVEL == LVL_7;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      reply_q <= 1'b0;
      cont_q <= 1'b0;
      oe_q <= 1'b0;
      drv_q <= '0;
      ack_out_q <= 1'b0;
      block_q <= 1'b0;
      pend_q <= 1'b0;
      din_q <= 1'b0;
      hold_q <= '0;
      irq_q <= '0;
      occ_q <= '0;
    end else begin
      st_q <= st_d;
      reply_q <= reply_d;
      cont_q <= cont_d;
      oe_q <= oe_d;
      drv_q <= drv_d;
      ack_out_q <= ack_out_d;
      block_q <= block_d;
      pend_q <= pend_d;
      din_q <= din_d;
      hold_q <= hold_d;
      irq_q <= irq_d;
      occ_q <= occ_d;
    end
  end

  always_comb begin
    o_slave_reply = reply_q;
    o_refresh_block_continue = cont_q;
    o_muxed_addr_data = drv_q;
    o_muxed_addr_data_oe = oe_q;
    o_ack_chain_out = ack_out_q;
    o_irq = irq_q;
  end
endmodule

// ==== hdl/bkp_pkg.sv ====
// Package: constants and types for the backplane slave block
package bkp_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  // Block-continue must settle within this many ns of reply
  localparam int unsigned CONT_SETTLE_NS = 75;
  localparam int unsigned CONT_SETTLE_CYC =
    (CONT_SETTLE_NS / CLK_PERIOD_NS < 1) ? 1 : CONT_SETTLE_NS / CLK_PERIOD_NS;
  // Hold of block-continue after strobe negation
  localparam int unsigned CONT_HOLD_NS = 20;
  localparam int unsigned CONT_HOLD_CYC =
    (CONT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned VEC_W = 16;
  localparam logic [VEC_W-1:0] VEC_LIMIT = 16'h0200; // Octal 001000
  localparam logic [VEC_W-1:0] VEC_DEFAULT = 16'h0040; // Arbitrary vector
  localparam logic [1:0] LVL_4 = 2'h0;
  localparam logic [1:0] LVL_5 = 2'h1;
  localparam logic [1:0] LVL_6 = 2'h2;
  localparam logic [1:0] LVL_7 = 2'h3;
  localparam logic [2:0] LVL_BASE = 3'h4;

  typedef struct packed {
    logic cycle_sync;
    logic out_strobe;
    logic in_strobe;
    logic block_request_line;
    logic write_byte_ctl;
    logic ack_chain_in;
  } bus_in_s;

  typedef struct packed {
    logic irq_level_four;
    logic irq_level_five;
    logic irq_level_six;
    logic irq_level_seven;
  } irq_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_REPLY = 5'h02,
    ST_WAIT_NEG = 5'h04,
    ST_VEC = 5'h08,
    ST_PASS = 5'h10
  } slv_state_e;

endpackage

// ==== hdl/bkp_fifo.sv ====
// File: parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bkp_fifo
  import bkp_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    push = i_in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = i_out_ready && (cnt_q != '0);
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = i_in_data;
      wr_d = bump(wr_q);
    end
    if (pop) begin
      rd_d = bump(rd_q);
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    o_out_valid = (cnt_q != '0);
    o_out_data = mem_q[rd_q];
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule

// ==== bench/bkp_slave_asserts.sv ====
// Checker: port-level protocol assertions for the backplane slave
`timescale 1ns/1ps
module bkp_slave_asserts
  import bkp_pkg::*;
#(
  parameter logic [1:0] IRQ_LEVEL = LVL_4,
  parameter logic [VEC_W-1:0] VECTOR = VEC_DEFAULT,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire bus_in_s i_bus,
  input wire logic i_irq_enable,
  input wire logic i_irq_condition,
  input wire logic o_slave_reply,
  input wire logic o_refresh_block_continue,
  input wire logic [DATA_W-1:0] o_muxed_addr_data,
  input wire logic o_muxed_addr_data_oe,
  input wire logic o_ack_chain_out,
  input wire irq_s o_irq
);
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  localparam irq_s IRQ_EXP = irq_s'({1'b1, IRQ_LEVEL == LVL_5,
    IRQ_LEVEL[1], IRQ_LEVEL == LVL_7});
  logic vec_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) vec_q <= 1'b0;
    else vec_q <= o_muxed_addr_data_oe | (vec_q & o_irq.irq_level_four);
  end
  sequence strobe_seen;
    $past(i_bus.out_strobe | i_bus.in_strobe, 2);
  endsequence
  sequence reply_dropped;
    $fell(o_slave_reply) && $past(o_refresh_block_continue);
  endsequence
  reply_cause_a: assert property (
    $rose(o_slave_reply) |-> strobe_seen) else $error("reply no strobe");
  reply_release_a: assert property (
    $fell(o_slave_reply) |-> !$past(i_bus.out_strobe | i_bus.in_strobe, 2))
    else $error("reply dropped early");
  cont_with_reply_a: assert property (
    $rose(o_refresh_block_continue) |-> $rose(o_slave_reply))
    else $error("continue without reply");
  cont_hold_a: assert property (
    reply_dropped |-> o_refresh_block_continue) else $error("cont not held");
  irq_pattern_a: assert property (
    o_irq != '0 |-> o_irq == IRQ_EXP) else $error("bad irq lines");
  irq_cause_a: assert property (
    $rose(o_irq.irq_level_four) |-> $past(i_irq_enable & i_irq_condition))
    else $error("irq without cause");
  irq_hold_a: assert property (
    $fell(o_irq.irq_level_four) |-> vec_q) else $error("irq dropped early");
  vec_value_a: assert property (
    o_muxed_addr_data_oe |-> o_muxed_addr_data == VECTOR && VECTOR < VEC_LIMIT)
    else $error("bad vector");
  vec_block_a: assert property (
    o_muxed_addr_data_oe |-> !o_ack_chain_out) else $error("ack passed on");
  ack_pass_a: assert property (
    $rose(o_ack_chain_out) |-> $past(i_bus.ack_chain_in, 2))
    else $error("ack out without ack in");
endmodule
bind bkp_slave bkp_slave_asserts #(.IRQ_LEVEL(IRQ_LEVEL), .VECTOR(VECTOR),
  .DEPTH(DEPTH)) chk (.i_clock, .i_rst, .i_bus, .i_irq_enable,
  .i_irq_condition, .o_slave_reply, .o_refresh_block_continue,
  .o_muxed_addr_data, .o_muxed_addr_data_oe, .o_ack_chain_out, .o_irq);

// ==== bench/bkp_master_model.sv ====
// Partner: backplane master for block writes and interrupt acknowledge
`timescale 1ns/1ps
module bkp_master_model
  import bkp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reply,
  input wire logic i_cont,
  output bus_in_s o_bus,
  output logic [DATA_W-1:0] o_data
);
  // ****************
  // Master tasks
  // ****************
  // Processor priority field, below every request level
  logic [2:0] status_prio;
  initial begin
    o_bus = '0;
    o_data = 16'h5a5a;
    status_prio = 3'h3;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic wait_rep(input logic lvl, output bit ok);
    ok = 0;
    for (int i = 0; i < 1000 && !ok; i++) begin
      tick(1);
      ok = (i_reply === lvl);
    end
  endtask
  task automatic open_blk(input bit blk);
    o_bus.cycle_sync = 1;
    o_bus.block_request_line = blk;
    o_bus.write_byte_ctl = 1;
    tick(25);
  endtask
  task automatic word(input logic [15:0] d, output bit c, output bit ok);
    bit lo;
    o_data = d;
    tick(25);
    o_bus.out_strobe = 1;
    wait_rep(1, ok);
    tick(38);
    c = i_cont;
    o_bus.out_strobe = 0;
    tick(25);
    o_data = ~d;
    wait_rep(0, lo);
    ok = ok && lo;
    tick(38);
  endtask
  task automatic close_blk();
    tick(44);
    o_bus.cycle_sync = 0;
    o_bus.block_request_line = 0;
    o_bus.write_byte_ctl = 0;
    tick(50);
  endtask
  task automatic ack(input bit on);
    bit go;
    go = on && (LVL_BASE > status_prio);
    o_bus.in_strobe = go;
    if (go) tick(38);
    o_bus.ack_chain_in = go;
    tick(12);
  endtask
endmodule

// ==== bench/backplane_block_write_and_interrupt_test.sv ====
// Testbench: block writes, FIFO stall and interrupt arbitration
`timescale 1ns/1ps
module backplane_block_write_and_interrupt_test;
  import bkp_pkg::*;
  logic i_clock;
  logic i_rst;
  bus_in_s i_bus;
  logic [DATA_W-1:0] i_muxed_addr_data, o_muxed_addr_data, o_wr_data;
  irq_s i_irq_lines;
  irq_s o_irq;
  logic o_slave_reply, o_refresh_block_continue, o_muxed_addr_data_oe;
  logic o_ack_chain_out, o_wr_valid;
  logic i_irq_enable, i_irq_condition, i_wr_ready;
  logic [DATA_W-1:0] got_q[$];
  int fail_count = 0;
  int total_checks = 0;
  // ****************
  // Scenarios
  // ****************
  always #2 i_clock = ~i_clock;
  bkp_slave dut (.i_clock, .i_rst, .i_bus, .i_muxed_addr_data, .i_irq_lines,
    .o_slave_reply, .o_refresh_block_continue, .o_muxed_addr_data,
    .o_muxed_addr_data_oe, .o_ack_chain_out, .o_irq, .i_irq_enable,
    .i_irq_condition, .o_wr_valid, .i_wr_ready, .o_wr_data);
  bkp_master_model mst (.i_clock, .i_reply(o_slave_reply),
    .i_cont(o_refresh_block_continue), .o_bus(i_bus),
    .o_data(i_muxed_addr_data));
  always @(posedge i_clock) begin
    if (o_wr_valid === 1'b1 && i_wr_ready) got_q.push_back(o_wr_data);
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_block();
    bit c, ok;
    int blk;
    mst.open_blk(1'h1);
    blk = 0;
    for (int n = 0; n < 8; n++) begin
      mst.word(16'h1000 + 16'(n), c, ok);
      blk++;
      chk("reply", 1, 16'(ok));
      chk("cont", 16'(n < FIFO_DEPTH - 2), 16'(c));
      if (!c || blk == 8) begin
        mst.close_blk();
        mst.open_blk(1'h1);
        blk = 0;
      end
    end
    fork
      mst.word(16'h1008, c, ok);
      begin
        mst.tick(300);
        chk("stall", 0, 16'(o_slave_reply));
        i_wr_ready = 1;
      end
    join
    chk("late reply", 1, 16'(ok));
    mst.close_blk();
    chk("count", 9, 16'(got_q.size()));
    for (int n = 0; n < 9; n++) chk("word", 16'h1000 + 16'(n), got_q[n]);
  endtask
  task automatic t_single();
    bit c, ok;
    mst.open_blk(1'h0);
    mst.word(16'h2000, c, ok);
    chk("single reply", 1, 16'(ok));
    chk("single cont", 0, 16'(c));
    mst.close_blk();
    chk("single count", 10, 16'(got_q.size()));
    chk("single word", 16'h2000, got_q[9]);
  endtask
  task automatic t_irq();
    i_irq_condition = 1;
    mst.tick(8);
    chk("irq masked", 0, 16'(o_irq));
    i_irq_enable = 1;
    mst.tick(4);
    chk("irq lines", 16'h8, 16'(o_irq));
    i_irq_lines = 4'ha;
    mst.ack(1);
    chk("yield", 1, 16'(o_ack_chain_out));
    chk("no vector", 0, 16'(o_muxed_addr_data_oe));
    mst.ack(0);
    chk("irq held", 16'h8, 16'(o_irq));
    i_irq_lines = 4'h8;
    mst.ack(1);
    chk("vector", VEC_DEFAULT, o_muxed_addr_data);
    chk("vec reply", 1, 16'(o_slave_reply));
    chk("blocked", 0, 16'(o_ack_chain_out));
    i_irq_condition = 0;
    mst.ack(0);
    chk("irq drop", 0, 16'(o_irq));
    i_irq_lines = '0;
    mst.ack(1);
    chk("pass", 1, 16'(o_ack_chain_out));
    mst.ack(0);
  endtask
  initial begin
    i_clock = 1'h0;
    i_rst = 1'h1;
    i_irq_lines = '0;
    i_irq_enable = 1'h0;
    i_irq_condition = 1'h0;
    i_wr_ready = 1'h0;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock) i_rst = 0;
    chk("reset", 0, 16'({o_slave_reply, o_refresh_block_continue,
      o_muxed_addr_data_oe, o_ack_chain_out, o_wr_valid, o_irq}));
    t_block();
    t_single();
    t_irq();
    end_sim();
  end
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule
